//--- design/irq_ctrl_pkg.sv
// Purpose: shared constants, types and vector lookup of the two level interrupt controller
// Assumes: source index 0 is first in the polling order, index 10 is last
// Notes: register indices are word indices; the byte address is four times the index
package irq_ctrl_pkg;

    localparam int NUM_SOURCES = 11;   // independent interrupt sources
    localparam int ADDR_W = 12;        // apb address width

    ////////////////////////////////////////////////////////////////////////////
    // register word indices (byte address = index * 4)
    localparam logic [9:0] IDX_ENABLE_MAIN = 10'h0a8;
    localparam logic [9:0] IDX_ENABLE_PRIORITY_AUX = 10'h0a9;
    localparam logic [9:0] IDX_PRIORITY_MAIN = 10'h0b8;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h0c0;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h0c1;
    localparam logic [9:0] IDX_WATCHDOG_CFG = 10'h0c2;

    // reset values
    localparam logic [7:0] RST_ENABLE_MAIN = 8'h00;
    localparam logic [7:0] RST_ENABLE_PRIORITY_AUX = 8'ha0;
    localparam logic [7:0] RST_PRIORITY_MAIN = 8'h00;
    localparam logic [10:0] RST_IRQ_STATUS = 11'h000;
    localparam logic [10:0] RST_IRQ_MASK = 11'h000;
    localparam logic [7:0] RST_WATCHDOG_CFG = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // bit positions, main enable and main priority share one layout
    localparam int BIT_GLOBAL_GATE = 7;
    localparam int BIT_CONVERTER = 6;
    localparam int BIT_TIMER_TWO = 5;
    localparam int BIT_UART = 4;
    localparam int BIT_TIMER_ONE = 3;
    localparam int BIT_EXT_LINE1 = 2;
    localparam int BIT_TIMER_ZERO = 1;
    localparam int BIT_EXT_LINE0 = 0;
    // aux register
    localparam int BIT_INTERVAL_LEVEL = 6;
    localparam int BIT_SUPPLY_MON_LEVEL = 5;
    localparam int BIT_SPI_LEVEL = 4;
    localparam int BIT_AUX_MUST_ZERO = 3;
    localparam int BIT_INTERVAL_ON = 2;
    localparam int BIT_SUPPLY_MON_ON = 1;
    localparam int BIT_SPI_ON = 0;
    // watchdog config: mode bit and timeout field
    localparam int BIT_WATCHDOG_IRQ_MODE = 0;
    localparam int WD_TIMEOUT_LSB = 4;
    localparam int WD_TIMEOUT_MSB = 7;

    ////////////////////////////////////////////////////////////////////////////
    // source indices in polling order
    localparam logic [3:0] SRC_SUPPLY_MON = 4'h0;
    localparam logic [3:0] SRC_WATCHDOG = 4'h1;
    localparam logic [3:0] SRC_EXT_LINE0 = 4'h2;
    localparam logic [3:0] SRC_CONVERTER = 4'h3;
    localparam logic [3:0] SRC_TIMER_ZERO = 4'h4;
    localparam logic [3:0] SRC_EXT_LINE1 = 4'h5;
    localparam logic [3:0] SRC_TIMER_ONE = 4'h6;
    localparam logic [3:0] SRC_SPI = 4'h7;
    localparam logic [3:0] SRC_UART = 4'h8;
    localparam logic [3:0] SRC_TIMER_TWO = 4'h9;
    localparam logic [3:0] SRC_INTERVAL = 4'ha;

    // raw flags raised by the peripherals
    typedef struct packed {
        logic supply_mon_request;
        logic watchdog_request;
        logic ext_line0_flag;
        logic main_converter_ready;
        logic aux_converter_ready;
        logic timer_zero_overflow;
        logic ext_line1_flag;
        logic timer_one_overflow;
        logic spi_done_flag;
        logic uart_rx_done;
        logic uart_tx_done;
        logic timer_two_overflow;
        logic timer_two_external_flag;
        logic interval_counter_flag;
    } source_flags_s;

    // grant offered to the core
    typedef struct packed {
        logic valid;
        logic high_level;
        logic [3:0] source;
        logic [15:0] vector;
    } grant_s;

    // vector address of each source
    function automatic logic [15:0] vector_of(input logic [3:0] src);
        case (src)
            SRC_EXT_LINE0: vector_of = 16'h0003;
            SRC_TIMER_ZERO: vector_of = 16'h000b;
            SRC_EXT_LINE1: vector_of = 16'h0013;
            SRC_TIMER_ONE: vector_of = 16'h001b;
            SRC_UART: vector_of = 16'h0023;
            SRC_TIMER_TWO: vector_of = 16'h002b;
            SRC_CONVERTER: vector_of = 16'h0033;
            SRC_SPI: vector_of = 16'h003b;
            SRC_SUPPLY_MON: vector_of = 16'h0043;
            SRC_INTERVAL: vector_of = 16'h0053;
            SRC_WATCHDOG: vector_of = 16'h005b;
            default: vector_of = 16'h0000;
        endcase
    endfunction

endpackage

//--- design/two_level_interrupt_controller.sv
// Purpose: eleven source, two level interrupt controller with apb registers
// Assumes: source flags come from logic on clk; the core acks a grant and pulses return at end of service
// Notes: watchdog bypasses the global gate and is always high level
//
// Notes on behaviour
// - eleven sources, two priority levels
// - main enable bit 7 gates maskable sources
// - main enable holds per source enables
// - main priority bits, same layout, bit7 reserved
// - aux register priority bits 6,5,4
// - aux register enable bits 2,1,0
// - high request preempts low service routine
// - simultaneous levels: high granted first
// - same level never preempts running routine
// - fixed polling order within one level
// - grant tells core to push program counter
// - granted source supplies its vector address
// - watchdog interrupts only in interrupt mode
// - watchdog always high priority
// - global gate never masks watchdog
// - watchdog interrupt needs nonzero timeout
`timescale 1ns/1ps

module two_level_interrupt_controller (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [irq_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire irq_ctrl_pkg::source_flags_s flags,
    output irq_ctrl_pkg::grant_s grant,
    input wire logic irq_ack,
    input wire logic irq_return,
    output logic push_pc,
    output logic watchdog_reset_req,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // state declarations
    typedef enum logic {ST_IDLE, ST_OFFER} offer_state_e;

    offer_state_e state_reg, state_next;
    logic [7:0] enable_main_reg, enable_main_next;   // global gate and enables
    logic [7:0] aux_reg, aux_next;                   // aux priorities and enables
    logic [7:0] priority_main_reg, priority_main_next;
    logic [7:0] wd_cfg_reg, wd_cfg_next;             // watchdog mode and timeout
    logic [10:0] status_reg, status_next;            // sticky event bits
    logic [10:0] mask_reg, mask_next;
    logic [10:0] raw_prev_reg, raw_prev_next;        // for rising edge events
    logic [31:0] prdata_reg, prdata_next;
    logic wd_pend_reg, wd_pend_next;                 // latched watchdog timeout
    logic in_high_reg, in_high_next;                 // high level routine running
    logic in_low_reg, in_low_next;                   // low level routine running
    irq_ctrl_pkg::grant_s grant_reg, grant_next;
    logic push_pc_reg, push_pc_next;
    logic wd_reset_reg, wd_reset_next;

    logic [10:0] raw;       // per source request before enables
    logic [10:0] req;       // enabled and gated requests
    logic [10:0] level;     // one means high level
    logic [10:0] hi_req;
    logic [10:0] lo_req;
    logic [10:0] cand;      // set allowed to win now
    logic [3:0] win_idx;
    logic win_found;
    logic start_offer;
    logic wd_irq_ok;
    logic setup;
    logic access;
    logic mapped;
    logic [9:0] word_idx;
    logic [10:0] status_clr;

    ////////////////////////////////////////////////////////////////////////////
    // lowest set index wins, so index order is the polling order
    function automatic logic [4:0] first_set(input logic [10:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = irq_ctrl_pkg::NUM_SOURCES - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 4'(i)};
            end
        end
        first_set = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // source requests, enables and levels
    always_comb begin
        raw = '0;
        raw[irq_ctrl_pkg::SRC_SUPPLY_MON] = flags.supply_mon_request;
        raw[irq_ctrl_pkg::SRC_WATCHDOG] = wd_pend_reg;
        raw[irq_ctrl_pkg::SRC_EXT_LINE0] = flags.ext_line0_flag;
        raw[irq_ctrl_pkg::SRC_CONVERTER] = flags.main_converter_ready | flags.aux_converter_ready;
        raw[irq_ctrl_pkg::SRC_TIMER_ZERO] = flags.timer_zero_overflow;
        raw[irq_ctrl_pkg::SRC_EXT_LINE1] = flags.ext_line1_flag;
        raw[irq_ctrl_pkg::SRC_TIMER_ONE] = flags.timer_one_overflow;
        raw[irq_ctrl_pkg::SRC_SPI] = flags.spi_done_flag;
        raw[irq_ctrl_pkg::SRC_UART] = flags.uart_rx_done | flags.uart_tx_done;
        raw[irq_ctrl_pkg::SRC_TIMER_TWO] = flags.timer_two_overflow | flags.timer_two_external_flag;
        raw[irq_ctrl_pkg::SRC_INTERVAL] = flags.interval_counter_flag;
        // individual enables
        req = '0;
        req[irq_ctrl_pkg::SRC_SUPPLY_MON] = aux_reg[irq_ctrl_pkg::BIT_SUPPLY_MON_ON];
        req[irq_ctrl_pkg::SRC_EXT_LINE0] = enable_main_reg[irq_ctrl_pkg::BIT_EXT_LINE0];
        req[irq_ctrl_pkg::SRC_CONVERTER] = enable_main_reg[irq_ctrl_pkg::BIT_CONVERTER];
        req[irq_ctrl_pkg::SRC_TIMER_ZERO] = enable_main_reg[irq_ctrl_pkg::BIT_TIMER_ZERO];
        req[irq_ctrl_pkg::SRC_EXT_LINE1] = enable_main_reg[irq_ctrl_pkg::BIT_EXT_LINE1];
        req[irq_ctrl_pkg::SRC_TIMER_ONE] = enable_main_reg[irq_ctrl_pkg::BIT_TIMER_ONE];
        req[irq_ctrl_pkg::SRC_SPI] = aux_reg[irq_ctrl_pkg::BIT_SPI_ON];
        req[irq_ctrl_pkg::SRC_UART] = enable_main_reg[irq_ctrl_pkg::BIT_UART];
        req[irq_ctrl_pkg::SRC_TIMER_TWO] = enable_main_reg[irq_ctrl_pkg::BIT_TIMER_TWO];
        req[irq_ctrl_pkg::SRC_INTERVAL] = aux_reg[irq_ctrl_pkg::BIT_INTERVAL_ON];
        // global gate, watchdog stays outside it
        req = req & raw & {11{enable_main_reg[irq_ctrl_pkg::BIT_GLOBAL_GATE]}};
        req[irq_ctrl_pkg::SRC_WATCHDOG] = wd_pend_reg;
        // levels
        level = '0;
        level[irq_ctrl_pkg::SRC_SUPPLY_MON] = aux_reg[irq_ctrl_pkg::BIT_SUPPLY_MON_LEVEL];
        level[irq_ctrl_pkg::SRC_WATCHDOG] = 1'b1;
        level[irq_ctrl_pkg::SRC_EXT_LINE0] = priority_main_reg[irq_ctrl_pkg::BIT_EXT_LINE0];
        level[irq_ctrl_pkg::SRC_CONVERTER] = priority_main_reg[irq_ctrl_pkg::BIT_CONVERTER];
        level[irq_ctrl_pkg::SRC_TIMER_ZERO] = priority_main_reg[irq_ctrl_pkg::BIT_TIMER_ZERO];
        level[irq_ctrl_pkg::SRC_EXT_LINE1] = priority_main_reg[irq_ctrl_pkg::BIT_EXT_LINE1];
        level[irq_ctrl_pkg::SRC_TIMER_ONE] = priority_main_reg[irq_ctrl_pkg::BIT_TIMER_ONE];
        level[irq_ctrl_pkg::SRC_SPI] = aux_reg[irq_ctrl_pkg::BIT_SPI_LEVEL];
        level[irq_ctrl_pkg::SRC_UART] = priority_main_reg[irq_ctrl_pkg::BIT_UART];
        level[irq_ctrl_pkg::SRC_TIMER_TWO] = priority_main_reg[irq_ctrl_pkg::BIT_TIMER_TWO];
        level[irq_ctrl_pkg::SRC_INTERVAL] = aux_reg[irq_ctrl_pkg::BIT_INTERVAL_LEVEL];
    end

    ////////////////////////////////////////////////////////////////////////////
    // arbitration: high set beats low set, polling order inside a set
    always_comb begin
        hi_req = req & level;
        lo_req = req & ~level;
        cand = '0;
        if (!in_high_reg && (|hi_req)) begin
            cand = hi_req;
        end else if (!in_high_reg && !in_low_reg) begin
            cand = lo_req;
        end
        {win_found, win_idx} = first_set(cand);
        start_offer = (state_reg == ST_IDLE) && win_found;
    end

    ////////////////////////////////////////////////////////////////////////////
    // grant and in-service tracking
    always_comb begin
        state_next = state_reg;
        grant_next = grant_reg;
        in_high_next = in_high_reg;
        in_low_next = in_low_reg;
        push_pc_next = 1'b0;
        // a return closes the innermost routine, which is the high one if both run
        if (irq_return) begin
            if (in_high_reg) begin
                in_high_next = 1'b0;
            end else begin
                in_low_next = 1'b0;
            end
        end
        case (state_reg)
            ST_IDLE: begin
                if (start_offer) begin
                    grant_next.valid = 1'b1;
                    grant_next.source = win_idx;
                    grant_next.high_level = level[win_idx];
                    grant_next.vector = irq_ctrl_pkg::vector_of(win_idx);
                    state_next = ST_OFFER;
                end
            end
            ST_OFFER: begin
                // offer held until taken; a late high request waits one grant
                if (irq_ack) begin
                    grant_next.valid = 1'b0;
                    push_pc_next = 1'b1;
                    if (grant_reg.high_level) begin
                        in_high_next = 1'b1;
                    end else begin
                        in_low_next = 1'b1;
                    end
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                grant_next.valid = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // watchdog timeout handling
    always_comb begin
        wd_irq_ok = wd_cfg_reg[irq_ctrl_pkg::BIT_WATCHDOG_IRQ_MODE]
                    && (wd_cfg_reg[irq_ctrl_pkg::WD_TIMEOUT_MSB:irq_ctrl_pkg::WD_TIMEOUT_LSB] != 4'h0);
        wd_pend_next = wd_pend_reg;
        if ((state_reg == ST_OFFER) && irq_ack && (grant_reg.source == irq_ctrl_pkg::SRC_WATCHDOG)) begin
            wd_pend_next = 1'b0;
        end
        // set wins over the clear of the same cycle
        if (flags.watchdog_request && wd_irq_ok) begin
            wd_pend_next = 1'b1;
        end
        wd_reset_next = flags.watchdog_request
                        && !wd_cfg_reg[irq_ctrl_pkg::BIT_WATCHDOG_IRQ_MODE];
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states, read data captured in setup
    always_comb begin
        setup = psel && !penable;
        access = psel && penable;
        word_idx = paddr[irq_ctrl_pkg::ADDR_W-1:2];
        mapped = (paddr[1:0] == 2'b00) && ((word_idx == irq_ctrl_pkg::IDX_ENABLE_MAIN)
                 || (word_idx == irq_ctrl_pkg::IDX_ENABLE_PRIORITY_AUX)
                 || (word_idx == irq_ctrl_pkg::IDX_PRIORITY_MAIN)
                 || (word_idx == irq_ctrl_pkg::IDX_IRQ_STATUS)
                 || (word_idx == irq_ctrl_pkg::IDX_IRQ_MASK)
                 || (word_idx == irq_ctrl_pkg::IDX_WATCHDOG_CFG));
        prdata_next = prdata_reg;
        if (setup && !pwrite) begin
            case (mapped ? word_idx : 10'h000)
                irq_ctrl_pkg::IDX_ENABLE_MAIN: prdata_next = {24'h000000, enable_main_reg};
                irq_ctrl_pkg::IDX_ENABLE_PRIORITY_AUX: prdata_next = {24'h000000, aux_reg};
                irq_ctrl_pkg::IDX_PRIORITY_MAIN: prdata_next = {24'h000000, priority_main_reg};
                irq_ctrl_pkg::IDX_IRQ_STATUS: prdata_next = {21'h00000, status_reg};
                irq_ctrl_pkg::IDX_IRQ_MASK: prdata_next = {21'h00000, mask_reg};
                irq_ctrl_pkg::IDX_WATCHDOG_CFG: prdata_next = {24'h000000, wd_cfg_reg};
                default: prdata_next = 32'h00000000;
            endcase
        end
        enable_main_next = enable_main_reg;
        aux_next = aux_reg;
        priority_main_next = priority_main_reg;
        mask_next = mask_reg;
        wd_cfg_next = wd_cfg_reg;
        status_clr = '0;
        if (access && pwrite && mapped) begin
            case (word_idx)
                irq_ctrl_pkg::IDX_ENABLE_MAIN: enable_main_next = pwdata[7:0];
                // bit 3 is kept zero whatever software writes
                irq_ctrl_pkg::IDX_ENABLE_PRIORITY_AUX: aux_next = pwdata[7:0] & 8'hf7;
                irq_ctrl_pkg::IDX_PRIORITY_MAIN: priority_main_next = {1'b0, pwdata[6:0]};
                irq_ctrl_pkg::IDX_IRQ_MASK: mask_next = pwdata[10:0];
                irq_ctrl_pkg::IDX_WATCHDOG_CFG: wd_cfg_next = pwdata[7:0] & 8'hf1;
                default: status_clr = '0;
            endcase
        end
        // clear only what the read returned, so an event after setup survives
        if (access && !pwrite && (word_idx == irq_ctrl_pkg::IDX_IRQ_STATUS) && mapped) begin
            status_clr = prdata_reg[10:0];
        end
        raw_prev_next = raw;
        status_next = (status_reg & ~status_clr) | (raw & ~raw_prev_reg);
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            enable_main_reg <= irq_ctrl_pkg::RST_ENABLE_MAIN;
            aux_reg <= irq_ctrl_pkg::RST_ENABLE_PRIORITY_AUX;
            priority_main_reg <= irq_ctrl_pkg::RST_PRIORITY_MAIN;
            wd_cfg_reg <= irq_ctrl_pkg::RST_WATCHDOG_CFG;
            status_reg <= irq_ctrl_pkg::RST_IRQ_STATUS;
            mask_reg <= irq_ctrl_pkg::RST_IRQ_MASK;
            raw_prev_reg <= '0;
            prdata_reg <= 32'h00000000;
            wd_pend_reg <= 1'b0;
            in_high_reg <= 1'b0;
            in_low_reg <= 1'b0;
            grant_reg <= '0;
            push_pc_reg <= 1'b0;
            wd_reset_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            enable_main_reg <= enable_main_next;
            aux_reg <= aux_next;
            priority_main_reg <= priority_main_next;
            wd_cfg_reg <= wd_cfg_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            raw_prev_reg <= raw_prev_next;
            prdata_reg <= prdata_next;
            wd_pend_reg <= wd_pend_next;
            in_high_reg <= in_high_next;
            in_low_reg <= in_low_next;
            grant_reg <= grant_next;
            push_pc_reg <= push_pc_next;
            wd_reset_reg <= wd_reset_next;
        end
    end

    // outputs
    assign prdata = prdata_reg;
    assign pready = access;
    assign pslverr = access && !mapped;
    assign grant = grant_reg;
    assign push_pc = push_pc_reg;
    assign watchdog_reset_req = wd_reset_reg;
    assign irq_out = |(status_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_vector_lookup: assert property (@(posedge clk) disable iff (sys_rst)
        start_offer |=> grant.valid && (grant.vector == irq_ctrl_pkg::vector_of($past(win_idx))))
        else $error("vector does not match granted source");

    chk_gate_closed: assert property (@(posedge clk) disable iff (sys_rst)
        start_offer && !enable_main_reg[irq_ctrl_pkg::BIT_GLOBAL_GATE]
        |-> win_idx == irq_ctrl_pkg::SRC_WATCHDOG)
        else $error("maskable source granted with gate closed");

    chk_wd_ungated: assert property (@(posedge clk) disable iff (sys_rst)
        wd_pend_reg && !in_high_reg && (state_reg == ST_IDLE) |=> grant.valid && grant.high_level)
        else $error("pending watchdog not granted at high level");

    chk_high_preempt: assert property (@(posedge clk) disable iff (sys_rst)
        in_low_reg && !in_high_reg && (|hi_req) && (state_reg == ST_IDLE) |=> grant.valid && grant.high_level)
        else $error("high request did not preempt low routine");

    chk_level_first: assert property (@(posedge clk) disable iff (sys_rst)
        start_offer && (|hi_req) && !in_high_reg |-> level[win_idx])
        else $error("low level granted over high level");

    chk_same_level: assert property (@(posedge clk) disable iff (sys_rst)
        in_high_reg || (in_low_reg && !(|hi_req)) |-> !start_offer)
        else $error("same level request preempted routine");

    chk_poll_order: assert property (@(posedge clk) disable iff (sys_rst)
        start_offer |-> ((cand & ((11'h001 << win_idx) - 11'h001)) == 11'h000) && cand[win_idx])
        else $error("polling order broken");

    chk_push_on_ack: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == ST_OFFER) && irq_ack |=> push_pc && !grant.valid ##1 !push_pc)
        else $error("push strobe missing after grant taken");

    chk_wd_reset_mode: assert property (@(posedge clk) disable iff (sys_rst)
        flags.watchdog_request |=> watchdog_reset_req == !$past(wd_cfg_reg[irq_ctrl_pkg::BIT_WATCHDOG_IRQ_MODE]))
        else $error("watchdog reset or interrupt choice wrong");

    chk_wd_zero_timeout: assert property (@(posedge clk) disable iff (sys_rst)
        flags.watchdog_request && !wd_pend_reg && !wd_irq_ok |=> !wd_pend_reg)
        else $error("watchdog pending with zero timeout or reset mode");

    chk_aux_bit3: assert property (@(posedge clk) disable iff (sys_rst)
        !aux_reg[irq_ctrl_pkg::BIT_AUX_MUST_ZERO])
        else $error("aux reserved bit set");

    chk_uart_combined: assert property (@(posedge clk) disable iff (sys_rst)
        (flags.uart_rx_done || flags.uart_tx_done) |-> raw[irq_ctrl_pkg::SRC_UART])
        else $error("uart flag lost");

endmodule

//--- verification/core_model.sv
// Purpose: core side of the grant handshake, acks offers and loads the vector
// Assumes: grant follows the valid/ack handshake of the controller
// Notes: acks one cycle into every offer; returns are driven by the bench
`timescale 1ns/1ps
module core_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire irq_ctrl_pkg::grant_s grant,
    output logic irq_ack,
    output logic [16:0] pc
);
    // ack drops at the taking edge so one offer is never taken twice
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_ack <= 1'b0;
            pc <= 17'h00000;
        end else begin
            irq_ack <= grant.valid & ~irq_ack;
            if (irq_ack && grant.valid) pc <= {grant.high_level, grant.vector};
        end
    end
endmodule

//--- verification/two_level_interrupt_controller_bench.sv
// Purpose: self-checking bench of the two level interrupt controller
// Assumes: core_model takes grants; the bench ends routines with irq_return
// Notes: each step sets all flags, then runs one op; status bit = polling slot
`timescale 1ns/1ps
module two_level_interrupt_controller_bench;
    logic clk = 1'b0;
    logic sys_rst, psel, penable, pwrite, pready, pslverr, irq_ack, irq_return, push_pc, wd_rst, irq_out, bad;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [32:0] rd;
    logic [19:0] a;
    logic [3:0] op;
    logic [16:0] pc;
    irq_ctrl_pkg::source_flags_s fl;
    irq_ctrl_pkg::grant_s grant;
    int errors = 0, check_count = 0;
    // op[39:36] flags[33:20] arg[19:0]; op 0 take, 1 quiet, 2 return, 3 return+take, 4 write,
    // 5 read, 6 read to clear, 7 bad address, 8 one edge then look at {wd reset, irq_out}
    logic [39:0] steps [43] = '{
        40'h5_0000_2a4a0, 40'h7_0000_3fc00, 40'h4_0000_2e002, 40'h4_0000_2a07f,
        40'h1_0900_00000, 40'h4_0900_2a0ff, 40'h0_0900_1000b, 40'h3_0800_00003,
        40'h0_0900_1000b, 40'h2_0880_00000, 40'h1_0880_00000, 40'h4_0880_2e000,
        40'h4_0880_2a407, 40'h3_0080_00013, 40'h3_2beb_00043, 40'h3_0beb_00003,
        40'h3_03eb_00033, 40'h3_01eb_0000b, 40'h3_00eb_00013, 40'h3_006b_0001b,
        40'h3_002b_0003b, 40'h3_000b_00023, 40'h3_0003_0002b, 40'h3_0001_00053,
        40'h4_0000_2a000, 40'h2_0000_00000, 40'h6_0000_30000, 40'h4_0000_30811,
        40'h8_1000_00000, 40'h8_0000_00000, 40'h0_0000_1005b, 40'h4_0000_304ff,
        40'h8_0000_00001, 40'h5_0000_30002, 40'h8_0000_00000, 40'h2_0000_00000,
        40'h4_0000_30810, 40'h8_1000_00000, 40'h8_0000_00002, 40'h4_0000_30801,
        40'h8_1000_00000, 40'h8_0000_00000, 40'h1_0000_00000};
    two_level_interrupt_controller DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flags(fl), .grant(grant), .irq_ack(irq_ack), .irq_return(irq_return), .push_pc(push_pc),
        .watchdog_reset_req(wd_rst), .irq_out(irq_out));
    core_model core (.clk(clk), .sys_rst(sys_rst), .grant(grant), .irq_ack(irq_ack), .pc(pc));
    initial forever #25 clk = ~clk;
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        errors += int'(seen !== exp);
    endtask
    // apb cycle; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, 24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = {pslverr, prdata};
        {psel, penable} <= 2'b00;
        @(posedge clk);
    endtask
    // skip one edge so a pulse from the previous grant is never reused
    task automatic take(input logic [16:0] exp);
        @(posedge clk);
        for (int i = 0; i < 40 && push_pc !== 1'b1; i++) @(posedge clk);
        chk(push_pc, 1'b1);
        chk(pc, exp);
    endtask
    task automatic fin();
        irq_return <= 1'b1;
        @(posedge clk);
        irq_return <= 1'b0;
    endtask
    task automatic quiet();
        bad = 1'b0;
        repeat (8) @(posedge clk) bad |= (grant.valid !== 1'b0);
        chk(bad, 1'b0);
    endtask
    task automatic wrap_up();
        if (errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #500000 errors++;
        wrap_up();
    end
    // main sequence: table driven, flags change together with each op
    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, irq_return, paddr, pwdata, fl} = '0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (steps[i]) begin
            fl <= steps[i][33:20];
            {op, a} = {steps[i][39:36], steps[i][19:0]};
            case (op)
                4'h0: take(a[16:0]);
                4'h1: quiet();
                4'h2, 4'h3: fin();
                4'h4: apb(1'b1, a[19:8], a[7:0]);
                4'h8: @(posedge clk);
                default: apb(1'b0, a[19:8], a[7:0]);
            endcase
            if (op == 4'h3) take(a[16:0]);
            if (op == 4'h5 || op == 4'h7) chk(rd, {op[1], 24'h000000, a[7:0]});
            if (op == 4'h8) chk({wd_rst, irq_out}, a[1:0]);
        end
        wrap_up();
    end
endmodule
